// >>> src/adc_seq_pkg.sv
// Shared constants, types and helpers for the converter sequencer.
// Assumes a 20 MHz system clock and an APB slave with an 8-bit byte address.
package adc_seq_pkg;

	// ==========================================================
	// Register map (byte addresses, one 32-bit word each)
	// ==========================================================
	localparam logic [7:0] ADDR_CTRL0 = 8'h00; // Channel, go, enable
	localparam logic [7:0] ADDR_CTRL1 = 8'h04; // Format, clock select, reference
	localparam logic [7:0] ADDR_TRIG = 8'h08; // Auto-trigger select register
	localparam logic [7:0] ADDR_RES_HIGH = 8'h0C; // Result high byte
	localparam logic [7:0] ADDR_RES_LOW = 8'h10; // Result low byte
	localparam logic [7:0] ADDR_STATUS = 8'h14; // Done flag, irq enable, state

	// ==========================================================
	// Field positions
	// ==========================================================
	localparam int CTRL0_ON = 0;
	localparam int CTRL0_GO = 1;
	localparam int CTRL0_CHAN_LSB = 2;
	localparam int CTRL1_VREF_LSB = 0;
	localparam int CTRL1_CS_LSB = 4;
	localparam int CTRL1_FM = 7;
	localparam int STAT_FLAG = 0;
	localparam int STAT_IE = 1;
	localparam int STAT_BUSY = 2;
	localparam int STAT_ACTIVE = 3;

	// ==========================================================
	// Widths and reset values
	// ==========================================================
	localparam int RESULT_W = 10;
	localparam int CHAN_W = 6;
	localparam int TRIG_SRCS = 16;
	localparam logic [5:0] RESET_CHAN = 6'h00;
	localparam logic [2:0] RESET_CS = 3'h0;
	localparam logic [1:0] RESET_VREF = 2'h0;
	localparam logic [3:0] RESET_TRIG = 4'h0;
	localparam logic [9:0] RESET_RESULT = 10'h000;
	localparam logic [9:0] SAR_FIRST_TRIAL = 10'h200; // Midscale trial
	localparam logic [3:0] SAR_FIRST_BIT = 4'h9;

	// ==========================================================
	// Timing
	// ==========================================================
	localparam int SYS_CLK_HZ = 20_000_000;
	localparam int INSTR_CYCLE_NS = 200; // One instruction cycle
	localparam int INSTR_DELAY_CLKS = (INSTR_CYCLE_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
	localparam logic [2:0] DELAY_LAST = 3'(INSTR_DELAY_CLKS - 1);

	// ==========================================================
	// Types
	// ==========================================================
	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_DELAY = 2'b01,
		ST_SAMPLE = 2'b10,
		ST_CONVERT = 2'b11
	} seq_state_t;

	// Controls toward the analog front end
	typedef struct packed
	{
		logic power; // Converter powered
		logic sample; // Sample switch closed
		logic [9:0] dac_code; // Present trial code
		logic [5:0] channel; // Input multiplexer
		logic [1:0] vref; // Positive reference select
	} analog_ctrl_t;

	// ==========================================================
	// Helpers
	// ==========================================================
	// Codes ending in 11 pick the internal RC oscillator
	function automatic logic cs_is_rc(input logic [2:0] cs);
		return cs[1:0] == 2'b11;
	endfunction : cs_is_rc

	// Terminal count of the system clock divider for each code
	function automatic logic [5:0] cs_div_last(input logic [2:0] cs);
		case (cs)
			3'b000: return 6'h01;
			3'b100: return 6'h03;
			3'b001: return 6'h07;
			3'b101: return 6'h0F;
			3'b010: return 6'h1F;
			3'b110: return 6'h3F;
			default: return 6'h00;
		endcase
	endfunction : cs_div_last

endpackage : adc_seq_pkg

// >>> src/conv_clock_gen.sv
// Bit-period tick generator for the converter sequencer.
// Assumes rc_tick is already synchronised to pclk and lasts one cycle.
module conv_clock_gen
	import adc_seq_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic [2:0] clk_sel,
	input wire logic rc_tick,
	input wire logic run,
	output logic tad_tick
);
	import adc_seq_pkg::*;

	// ==========================================================
	// Divider
	// ==========================================================
	logic [5:0] div_cnt; // Counts system clocks within one bit period
	wire logic use_rc = cs_is_rc(clk_sel);
	wire logic [5:0] div_last = cs_div_last(clk_sel);
	wire logic div_wrap = (div_cnt == div_last);

	// Counter restarts when idle so every system-clock conversion begins on a full period
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			div_cnt <= 6'h00;
			tad_tick <= 1'b0;
		end
		else if (clk_en)
		begin
			div_cnt <= (!run || div_wrap) ? 6'h00 : 6'(div_cnt + 6'h01);
			tad_tick <= run && (use_rc ? rc_tick : div_wrap);
		end
	end

endmodule : conv_clock_gen

// >>> src/adc_conversion_sequencer.sv
// Digital control of a 10-bit successive-approximation converter.
// Assumes APB from software, a comparator output on pclk and async trigger pins.
module adc_conversion_sequencer
	import adc_seq_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sleep_mode,
	input wire logic peripheral_irq_enable,
	input wire logic global_irq_enable,
	input wire logic rc_osc,
	input wire logic [15:0] trig_in,
	input wire logic cmp_high,
	output adc_seq_pkg::analog_ctrl_t analog_out,
	output logic irq_event,
	output logic wake_request,
	output logic isr_request
);
	import adc_seq_pkg::*;

	// ==========================================================
	// Registers and state
	// ==========================================================
	logic on; // Module enable
	logic go; // Conversion in progress
	logic [5:0] chan; // Channel select field
	logic result_format_select; // 1 right, 0 left
	logic [2:0] clk_sel; // Conversion clock select
	logic [1:0] vref; // Reference select
	logic [3:0] auto_trigger_source_field; // 0 means no trigger
	logic conv_done_flag; // Sticky completion flag
	logic conv_irq_enable; // Interrupt enable
	logic [9:0] result_pair; // Stored right-justified
	logic [9:0] sar; // Trial code
	logic [3:0] bit_idx; // Bit under test
	logic [2:0] delay_cnt; // Instruction-cycle start delay
	logic trig_pending; // Edge caught during sleep
	logic sleep_off; // Converter powered down by sleep
	logic bus_held; // Setup seen, answer ready
	seq_state_t state;
	seq_state_t next_state;

	// ==========================================================
	// Pin synchronisers (three stages, stable on stages 2 and 3)
	// ==========================================================
	logic [15:0] trig_s1, trig_s2, trig_s3, trig_stable;
	logic rc_s1, rc_s2, rc_s3, rc_stable;
	wire logic [15:0] trig_rise = trig_s2 & trig_s3 & ~trig_stable;
	wire logic [15:0] next_trig_stable = (trig_s2 & trig_s3) | (trig_stable & (trig_s2 ^ trig_s3));
	wire logic rc_tick = rc_s2 & rc_s3 & ~rc_stable;
	wire logic next_rc_stable = (rc_s2 & rc_s3) | (rc_stable & (rc_s2 ^ rc_s3));

	// Stage one feeds only stage two
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			{trig_s1, trig_s2, trig_s3, trig_stable} <= {4{16'h0000}};
			{rc_s1, rc_s2, rc_s3, rc_stable} <= 4'h0;
		end
		else if (clk_en)
		begin
			{trig_s1, trig_s2, trig_s3, trig_stable} <= {trig_in, trig_s1, trig_s2, next_trig_stable};
			{rc_s1, rc_s2, rc_s3, rc_stable} <= {rc_osc, rc_s1, rc_s2, next_rc_stable};
		end
	end

	// ==========================================================
	// Bit-period tick
	// ==========================================================
	logic tad_tick;
	wire logic converting = (state == ST_SAMPLE) || (state == ST_CONVERT);

	conv_clock_gen u_clk
	(
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.clk_sel(clk_sel),
		.rc_tick(rc_tick),
		.run(converting),
		.tad_tick(tad_tick)
	);

	// ==========================================================
	// APB decode
	// ==========================================================
	wire logic addr_ok = (paddr == ADDR_CTRL0) || (paddr == ADDR_CTRL1) || (paddr == ADDR_TRIG)
		|| (paddr == ADDR_RES_HIGH) || (paddr == ADDR_RES_LOW) || (paddr == ADDR_STATUS);
	assign pready = penable && bus_held && clk_en;
	assign pslverr = psel && penable && pready && !addr_ok;
	wire logic wr = psel && penable && pready && pwrite && addr_ok;
	wire logic wr_ctrl0 = wr && (paddr == ADDR_CTRL0);
	wire logic wr_status = wr && (paddr == ADDR_STATUS);
	wire logic next_on = wr_ctrl0 ? pwdata[CTRL0_ON] : on;

	// Justified views of the stored result
	wire logic [7:0] res_high_view = result_format_select
		? {6'h00, result_pair[9:8]} : result_pair[9:2];
	wire logic [7:0] res_low_view = result_format_select
		? result_pair[7:0] : {result_pair[1:0], 6'h00};
	wire logic [7:0] status_view = {4'h0, on && !sleep_off, converting, conv_irq_enable,
		conv_done_flag};

	logic [7:0] rd_byte;
	always_comb
	begin
		case (paddr)
			ADDR_CTRL0: rd_byte = {chan, go, on};
			ADDR_CTRL1: rd_byte = {result_format_select, clk_sel, 2'b00, vref};
			ADDR_TRIG: rd_byte = {4'h0, auto_trigger_source_field};
			ADDR_RES_HIGH: rd_byte = res_high_view;
			ADDR_RES_LOW: rd_byte = res_low_view;
			ADDR_STATUS: rd_byte = status_view;
			default: rd_byte = 8'h00;
		endcase
	end

	// Read data is caught in the setup cycle, answer follows in the access cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h00000000;
			bus_held <= 1'b0;
		end
		else if (clk_en)
		begin
			bus_held <= psel && !(penable && pready);
			if (psel && !penable)
				prdata <= {24'h000000, rd_byte};
		end
	end

	// ==========================================================
	// Start, abort and completion conditions
	// ==========================================================
	wire logic rc_sel = cs_is_rc(clk_sel);
	wire logic sel_edge = (auto_trigger_source_field != 4'h0)
		&& trig_rise[auto_trigger_source_field];
	wire logic sleep_abort = sleep_mode && !rc_sel && (state != ST_IDLE);
	wire logic active = on && !sleep_off;
	// Enable must already be set, so go in the enabling write is ignored
	wire logic sw_start = wr_ctrl0 && pwdata[CTRL0_GO] && on;
	wire logic trig_start = on && !sleep_mode && !go && (trig_pending || sel_edge);
	wire logic abort = (state != ST_IDLE) && (!go || !active || sleep_abort);
	wire logic done_pulse = clk_en && (state == ST_CONVERT) && tad_tick
		&& (bit_idx == 4'h0) && !abort;
	wire logic [9:0] bit_mask = 10'h001 << bit_idx;
	wire logic [9:0] sar_kept = cmp_high ? sar : (sar & ~bit_mask);
	wire logic [9:0] next_sar = (bit_idx == 4'h0) ? sar_kept : (sar_kept | (bit_mask >> 1));
	wire logic next_sleep_off = sleep_mode
		&& (sleep_off || !rc_sel || (done_pulse && !conv_irq_enable));

	// ==========================================================
	// Sequencer state machine
	// ==========================================================
	always_comb
	begin
		next_state = state;
		case (state)
			ST_IDLE:
				if (go && active && !(sleep_mode && !rc_sel))
					next_state = rc_sel ? ST_DELAY : ST_SAMPLE;
			ST_DELAY:
				if (delay_cnt == 3'h0)
					next_state = ST_SAMPLE;
			ST_SAMPLE:
				if (tad_tick)
					next_state = ST_CONVERT;
			ST_CONVERT:
				if (done_pulse)
					next_state = ST_IDLE;
			default:
				next_state = ST_IDLE;
		endcase
		if (abort)
			next_state = ST_IDLE;
	end

	// State, trial code and delay counter
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= ST_IDLE;
			sar <= 10'h000;
			bit_idx <= 4'h0;
			delay_cnt <= 3'h0;
		end
		else if (clk_en)
		begin
			state <= next_state;
			if (state == ST_IDLE)
				delay_cnt <= DELAY_LAST;
			else if (state == ST_DELAY)
				delay_cnt <= 3'(delay_cnt - 3'h1);
			if (state == ST_SAMPLE)
			begin
				sar <= SAR_FIRST_TRIAL;
				bit_idx <= SAR_FIRST_BIT;
			end
			else if ((state == ST_CONVERT) && tad_tick && (bit_idx != 4'h0))
			begin
				sar <= next_sar;
				bit_idx <= 4'(bit_idx - 4'h1);
			end
		end
	end

	// ==========================================================
	// Control registers, go bit, flag and result
	// ==========================================================
	// Completion updates go, flag and result on the same edge; the set beats a clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			on <= 1'b0;
			go <= 1'b0;
			chan <= RESET_CHAN;
			result_format_select <= 1'b0;
			clk_sel <= RESET_CS;
			vref <= RESET_VREF;
			auto_trigger_source_field <= RESET_TRIG;
			conv_done_flag <= 1'b0;
			conv_irq_enable <= 1'b0;
			result_pair <= RESET_RESULT;
			trig_pending <= 1'b0;
			sleep_off <= 1'b0;
		end
		else if (clk_en)
		begin
			sleep_off <= next_sleep_off;
			trig_pending <= on && !trig_start
				&& (trig_pending || (sel_edge && sleep_mode));
			if (wr_ctrl0)
			begin
				on <= pwdata[CTRL0_ON];
				chan <= pwdata[CTRL0_CHAN_LSB +: CHAN_W];
			end
			if (wr && (paddr == ADDR_CTRL1))
			begin
				result_format_select <= pwdata[CTRL1_FM];
				clk_sel <= pwdata[CTRL1_CS_LSB +: 3];
				vref <= pwdata[CTRL1_VREF_LSB +: 2];
			end
			if (wr && (paddr == ADDR_TRIG))
				auto_trigger_source_field <= pwdata[3:0];
			// Go: hardware clear, then start, then software clear
			if (done_pulse || sleep_abort || !next_on)
				go <= 1'b0;
			else if (sw_start || trig_start)
				go <= 1'b1;
			else if (wr_ctrl0 && !pwdata[CTRL0_GO])
				go <= 1'b0;
			if (done_pulse)
				conv_done_flag <= 1'b1;
			else if (wr_status)
				conv_done_flag <= pwdata[STAT_FLAG];
			if (wr_status)
				conv_irq_enable <= pwdata[STAT_IE];
			if (done_pulse)
				result_pair <= sar_kept;
			else if (wr && (paddr == ADDR_RES_HIGH))
				result_pair[9:8] <= pwdata[1:0];
			else if (wr && (paddr == ADDR_RES_LOW))
				result_pair[7:0] <= pwdata[7:0];
		end
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	assign analog_out = '{power: active, sample: (state == ST_SAMPLE), dac_code: sar,
		channel: chan, vref: vref};
	assign irq_event = conv_done_flag && conv_irq_enable;
	// Wake needs the peripheral gate; vectoring waits until the core is awake
	assign wake_request = sleep_mode && irq_event && peripheral_irq_enable;
	assign isr_request = !sleep_mode && irq_event && peripheral_irq_enable
		&& global_irq_enable;

	// ==========================================================
	// Assertions
	// ==========================================================
	property p_off_idle;
		@(posedge pclk) disable iff (!presetn)
		clk_en && !on |=> state == ST_IDLE;
	endproperty
	a_off_idle: assert property (p_off_idle) else $error("busy while disabled");

	property p_done_update;
		@(posedge pclk) disable iff (!presetn)
		done_pulse |=> !go && conv_done_flag && (result_pair == $past(sar_kept));
	endproperty
	a_done_update: assert property (p_done_update) else $error("completion update");

	property p_flag_no_ie;
		@(posedge pclk) disable iff (!presetn)
		done_pulse && !conv_irq_enable |=> conv_done_flag ##1 (conv_done_flag || $past(wr_status));
	endproperty
	a_flag_no_ie: assert property (p_flag_no_ie) else $error("flag lost");

	property p_irq;
		@(posedge pclk) disable iff (!presetn)
		done_pulse && conv_irq_enable |=> irq_event;
	endproperty
	a_irq: assert property (p_irq) else $error("no interrupt event");

	property p_sleep_abort;
		@(posedge pclk) disable iff (!presetn)
		clk_en && sleep_mode && !rc_sel && (state != ST_IDLE) && on
			|=> (state == ST_IDLE) && !go && on;
	endproperty
	a_sleep_abort: assert property (p_sleep_abort) else $error("sleep abort");

	property p_trig_latch;
		@(posedge pclk) disable iff (!presetn)
		clk_en && sleep_mode && on && sel_edge |=> trig_pending && !$rose(go);
	endproperty
	a_trig_latch: assert property (p_trig_latch) else $error("trigger not held");

	property p_rc_delay;
		@(posedge pclk) disable iff (!presetn)
		clk_en && (state == ST_IDLE) && (next_state != ST_IDLE) && rc_sel
			|=> state == ST_DELAY;
	endproperty
	a_rc_delay: assert property (p_rc_delay) else $error("no start delay");

	property p_justify;
		@(posedge pclk) disable iff (!presetn)
		result_format_select ? (res_high_view[7:2] == 6'h00) : (res_low_view[5:0] == 6'h00);
	endproperty
	a_justify: assert property (p_justify) else $error("zero fill wrong");

	property p_sleep_power;
		@(posedge pclk) disable iff (!presetn)
		done_pulse && sleep_mode && !conv_irq_enable |=> !analog_out.power && on;
	endproperty
	a_sleep_power: assert property (p_sleep_power) else $error("converter not off");

endmodule : adc_conversion_sequencer

// >>> bench/tb_top.sv
// Self-checking bench for the converter sequencer: APB master, comparator model, RC source.
// Assumes the package constants for the register map and a 20 MHz pclk.
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import adc_seq_pkg::*;

	// ==========================================================
	// Stimulus and observed signals
	// ==========================================================
	logic pclk = 1'b0; // System clock
	logic presetn = 1'b0; // Held low at start
	logic clk_en = 1'b1; // Tied: freezing is not exercised
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic sleep_mode = 1'b0; // CPU asleep
	logic peripheral_irq_enable = 1'b1;
	logic global_irq_enable = 1'b0;
	logic rc_osc = 1'b0; // Internal RC source
	logic [2:0] rc_cnt = 3'h0; // Divides pclk by 8 for the RC source
	logic [15:0] trig_in = 16'h0000;
	logic cmp_high; // Comparator model output
	logic [9:0] target = 10'h000; // Analog input as a code
	analog_ctrl_t analog_out;
	logic irq_event;
	logic wake_request;
	logic isr_request;
	logic [31:0] rdata; // Last read data
	logic berr; // Last error response
	int n_mismatch = 0;
	int samples_checked = 0;

	// ==========================================================
	// Clock, RC source and comparator
	// ==========================================================
	// 20 MHz system clock
	always #25 pclk = ~pclk;

	// RC source runs free at pclk/8; phase has no tie to the bus cycles
	always @(posedge pclk)
	begin
		rc_cnt <= rc_cnt + 3'h1;
		rc_osc <= rc_cnt[2];
	end

	// Ideal comparator: keeps the trial bit while the input is at or above it
	assign cmp_high = (analog_out.dac_code <= target);

	adc_conversion_sequencer i_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep_mode(sleep_mode),
		.peripheral_irq_enable(peripheral_irq_enable), .global_irq_enable(global_irq_enable),
		.rc_osc(rc_osc), .trig_in(trig_in), .cmp_high(cmp_high), .analog_out(analog_out),
		.irq_event(irq_event), .wake_request(wake_request), .isr_request(isr_request));

	// ==========================================================
	// Bus and compare tasks
	// ==========================================================
	// One APB transfer; waits for pready under a bound, takes the answer at that rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1)
		begin
			n_mismatch++;
			$display("ERROR %0t bus answer timed out", $time);
		end
		rdata = prdata;
		berr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Counts every comparison and reports a mismatch at once
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(rdata & m, e, "register read");
	endtask : rd

	// Waits for the interrupt level under a bound; n is the cycle count
	task automatic wait_irq(input int lim, output int n);
		n = 0;
		do
		begin
			@(negedge pclk);
			n++;
		end
		while (irq_event !== 1'b1 && n < lim);
	endtask : wait_irq

	// ==========================================================
	// Scenarios
	// ==========================================================
	// Reset values and an unmapped word
	task automatic t_reset;
		rd(ADDR_CTRL0, 32'hFFFF_FFFF, 32'h0000_0000); // Control reset
		rd(ADDR_CTRL1, 32'hFFFF_FFFF, 32'h0000_0000); // Format reset
		rd(ADDR_TRIG, 32'hFFFF_FFFF, 32'h0000_0000); // Trigger reset
		rd(ADDR_RES_HIGH, 32'hFFFF_FFFF, 32'h0000_0000); // Result reset
		rd(ADDR_RES_LOW, 32'hFFFF_FFFF, 32'h0000_0000); // Result reset
		rd(ADDR_STATUS, 32'hFFFF_FFFF, 32'h0000_0000); // Status reset
		apb(1'b0, 8'h18, 32'h0000_0000);
		chk({31'h0, berr}, 32'h0000_0001, "unmapped error"); // Refused
	endtask : t_reset

	// Go while disabled, then enable and go in one write: go ignored both times, enable taken
	task automatic t_enable;
		apb(1'b1, ADDR_CTRL0, 32'h0000_0002);
		repeat (100) @(posedge pclk);
		rd(ADDR_STATUS, 32'h0000_0001, 32'h0000_0000); // No conversion while off
		apb(1'b1, ADDR_CTRL0, 32'h0000_0003);
		rd(ADDR_CTRL0, 32'h0000_0003, 32'h0000_0001); // Go dropped on enabling
		chk({31'h0, analog_out.sample}, 32'h0000_0000, "no sampling"); // Idle
	endtask : t_enable

	// Software-started conversion at one clock code and format
	task automatic t_conv(input logic [2:0] cs, input logic fm, input int per, input logic ie,
		input logic [9:0] v);
		int n;
		logic [15:0] just;
		just = fm ? {6'h00, v} : {v, 6'h00};
		target <= v;
		apb(1'b1, ADDR_CTRL1, {24'h0, fm, cs, 4'h0});
		apb(1'b1, ADDR_STATUS, {30'h0, ie, 1'b0});
		repeat (8) @(posedge pclk); // Acquisition time before go
		apb(1'b1, ADDR_CTRL0, 32'h0000_0003);
		@(negedge pclk);
		@(negedge pclk);
		// System clocks start sampling at once, the RC clock one instruction later
		chk({31'h0, analog_out.sample}, {31'h0, cs[1:0] != 2'b11}, "start delay");
		if (ie)
		begin
			wait_irq(2000, n); // Result read only after the event
			chk({31'h0, (n >= 10 * per) && (n <= 11 * per + 6)}, 32'h1, "conv time");
		end
		else
		begin
			repeat (11 * per + 20) @(posedge pclk);
			chk({31'h0, irq_event}, 32'h0000_0000, "irq masked"); // No event
		end
		rd(ADDR_CTRL0, 32'h0000_0003, 32'h0000_0001); // Go cleared
		rd(ADDR_STATUS, 32'h0000_0003, {30'h0, ie, 1'b1}); // Flag set
		rd(ADDR_RES_HIGH, 32'hFFFF_FFFF, {24'h0, just[15:8]}); // High byte
		rd(ADDR_RES_LOW, 32'hFFFF_FFFF, {24'h0, just[7:0]}); // Low byte
		rd(ADDR_STATUS, 32'h0000_0001, 32'h0000_0001); // Reads leave flag
		apb(1'b1, ADDR_STATUS, {30'h0, ie, 1'b0});
		rd(ADDR_STATUS, 32'h0000_0001, 32'h0000_0000); // Software clear
	endtask : t_conv

	// Event, wake and service lines for every enable and sleep combination
	task automatic t_irq_lines;
		int n;
		apb(1'b1, ADDR_CTRL1, 32'h0000_0000);
		apb(1'b1, ADDR_STATUS, 32'h0000_0002);
		apb(1'b1, ADDR_CTRL0, 32'h0000_0003);
		wait_irq(100, n);
		for (int i = 0; i < 8; i++)
		begin
			@(posedge pclk);
			sleep_mode <= i[0];
			peripheral_irq_enable <= i[1];
			global_irq_enable <= i[2];
			@(negedge pclk);
			chk({29'h0, wake_request, isr_request, irq_event},
				{29'h0, i[0] & i[1], ~i[0] & i[1] & i[2], 1'b1}, "irq lines");
		end
		@(posedge pclk);
		sleep_mode <= 1'b0;
		peripheral_irq_enable <= 1'b1;
		global_irq_enable <= 1'b0;
		apb(1'b1, ADDR_STATUS, 32'h0000_0000);
		@(negedge pclk);
		chk({31'h0, irq_event}, 32'h0000_0000, "event after clear"); // Level drops
	endtask : t_irq_lines

	// Software writes land right-justified whatever the format
	task automatic t_result_write;
		apb(1'b1, ADDR_CTRL1, 32'h0000_0000);
		apb(1'b1, ADDR_RES_HIGH, 32'h0000_0001);
		apb(1'b1, ADDR_RES_LOW, 32'h0000_0023);
		rd(ADDR_RES_HIGH, 32'hFFFF_FFFF, 32'h0000_0048); // Left view of 0x123
		rd(ADDR_RES_LOW, 32'hFFFF_FFFF, 32'h0000_00C0); // Left view of 0x123
		apb(1'b1, ADDR_CTRL1, 32'h0000_0080);
		rd(ADDR_RES_HIGH, 32'hFFFF_FFFF, 32'h0000_0001); // Right view
	endtask : t_result_write

	// RC clock conversions in sleep: wake when enabled, power down when not
	task automatic t_rc_sleep;
		int n;
		target <= 10'h155;
		apb(1'b1, ADDR_CTRL1, 32'h0000_00B0);
		apb(1'b1, ADDR_STATUS, 32'h0000_0002);
		apb(1'b1, ADDR_CTRL0, 32'h0000_0003);
		sleep_mode <= 1'b1;
		wait_irq(2000, n);
		chk({31'h0, wake_request}, 32'h0000_0001, "wake"); // Completion wakes
		@(posedge pclk);
		sleep_mode <= 1'b0;
		rd(ADDR_RES_LOW, 32'hFFFF_FFFF, 32'h0000_0055); // Converted asleep
		apb(1'b1, ADDR_CTRL1, 32'h0000_00F0);
		apb(1'b1, ADDR_STATUS, 32'h0000_0000);
		apb(1'b1, ADDR_CTRL0, 32'h0000_0003);
		sleep_mode <= 1'b1;
		repeat (300) @(posedge pclk);
		chk({31'h0, wake_request}, 32'h0000_0000, "no wake"); // Stays asleep
		rd(ADDR_STATUS, 32'h0000_0009, 32'h0000_0001); // Done and powered down
		rd(ADDR_CTRL0, 32'h0000_0003, 32'h0000_0001); // Enable kept
		sleep_mode <= 1'b0;
		apb(1'b1, ADDR_STATUS, 32'h0000_0000);
	endtask : t_rc_sleep

	// Sleep on a system clock aborts the conversion in flight
	task automatic t_abort;
		apb(1'b1, ADDR_CTRL1, 32'h0000_00E0);
		apb(1'b1, ADDR_STATUS, 32'h0000_0002);
		apb(1'b1, ADDR_CTRL0, 32'h0000_0003);
		repeat (20) @(posedge pclk);
		sleep_mode <= 1'b1;
		repeat (5) @(posedge pclk);
		rd(ADDR_CTRL0, 32'h0000_0003, 32'h0000_0001); // Go dropped, enable kept
		rd(ADDR_STATUS, 32'h0000_0009, 32'h0000_0000); // Powered off, no flag
		sleep_mode <= 1'b0;
		repeat (800) @(posedge pclk);
		chk({31'h0, irq_event}, 32'h0000_0000, "aborted stays done-free");
	endtask : t_abort

	// Trigger edges: latched in sleep, selected source only when awake
	task automatic t_trigger;
		int n;
		apb(1'b1, ADDR_CTRL1, 32'h0000_0080);
		apb(1'b1, ADDR_TRIG, 32'h0000_0003);
		sleep_mode <= 1'b1;
		trig_in <= 16'h0008;
		repeat (20) @(posedge pclk);
		chk({31'h0, irq_event}, 32'h0000_0000, "held in sleep"); // Deferred
		sleep_mode <= 1'b0;
		wait_irq(300, n);
		chk({31'h0, irq_event}, 32'h0000_0001, "start after wake"); // Latched
		@(posedge pclk);
		trig_in <= 16'h0000;
		apb(1'b1, ADDR_STATUS, 32'h0000_0002);
		trig_in <= 16'h0020;
		repeat (100) @(posedge pclk); // Edges spaced beyond a conversion
		chk({31'h0, irq_event}, 32'h0000_0000, "other source"); // Unselected
		trig_in <= 16'h0028;
		wait_irq(300, n);
		chk({31'h0, irq_event}, 32'h0000_0001, "trigger start"); // Edge starts
		rd(ADDR_CTRL0, 32'h0000_0003, 32'h0000_0001); // Go cleared
		apb(1'b1, ADDR_TRIG, 32'h0000_0000);
		trig_in <= 16'h0000;
	endtask : t_trigger

	// ==========================================================
	// Verdict, watchdog and main sequence
	// ==========================================================
	task automatic final_report;
		$display("Comparisons %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : final_report

	// Whole run needs about 4000 cycles; the limit leaves wide margin
	initial
	begin
		#(60000 * 50);
		n_mismatch++;
		$display("ERROR %0t watchdog expired", $time);
		final_report();
	end

	initial
	begin
		logic [2:0] codes [6];
		int divs [6];
		codes = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
		divs = '{2, 4, 8, 16, 32, 64};
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_enable();
		for (int i = 0; i < 6; i++)
			t_conv(codes[i], i[0], divs[i], 1'b1, 10'h2A5 ^ 10'(i * 37));
		t_conv(3'h0, 1'b1, 2, 1'b0, 10'h000); // Flag without enable
		t_conv(3'h0, 1'b0, 2, 1'b1, 10'h3FF); // Full scale left
		t_conv(3'h3, 1'b1, 9, 1'b0, 10'h0AA); // RC clock start delay
		t_irq_lines();
		t_result_write();
		t_rc_sleep();
		t_abort();
		t_trigger();
		final_report();
	end

endmodule : tb_top
